//--- logic/fifo_flags_pkg.sv
package fifo_flags_pkg;
	localparam int unsigned DATA_W         = 9;
	localparam int unsigned ADDR_W         = 10;
	localparam int unsigned PTR_W          = 11;
	localparam logic [11:0] DEPTH          = 12'h400;
	localparam int unsigned CLK_PERIOD_NS  = 4;
	localparam int unsigned FLAG_SKEW_NS   = 6;
	localparam int unsigned PROG_SKEW_NS   = 15;
	localparam int unsigned FLAG_SKEW_CYC  = (FLAG_SKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned PROG_SKEW_CYC  = (PROG_SKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [9:0]  OFFSET_RST     = 10'h007;
	localparam int unsigned PIN_W          = 17;
	localparam logic [16:0] PIN_RST        = 17'h00000;
	localparam int unsigned PIN_WCLK       = 0;
	localparam int unsigned PIN_RCLK       = 1;
	localparam int unsigned PIN_WR_EN_N    = 2;
	localparam int unsigned PIN_WR_EN2     = 3;
	localparam int unsigned PIN_RD_EN_N    = 4;
	localparam int unsigned PIN_RD_EN2_N   = 5;
	localparam int unsigned PIN_RST_N      = 6;
	localparam int unsigned PIN_OE_N       = 7;
	localparam int unsigned PIN_DATA       = 8;
endpackage

//--- logic/fifo_ram.sv
`timescale 1ns/1ps
module fifo_ram (
	// Clock
	input  wire logic                                  clock,
	// Write port
	input  wire logic                                  we,
	input  wire logic [fifo_flags_pkg::ADDR_W-1:0]     waddr,
	input  wire logic [fifo_flags_pkg::DATA_W-1:0]     wdata,
	// Read port
	input  wire logic [fifo_flags_pkg::ADDR_W-1:0]     raddr,
	output logic      [fifo_flags_pkg::DATA_W-1:0]     rdata_ff
);
	import fifo_flags_pkg::*;

	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

	always_ff @(posedge clock) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge clock) begin
		rdata_ff <= mem[raddr];
	end
endmodule

//--- logic/dual_clock_fifo_flags.sv
// Notes on behaviour
// - Full flag releases on write edge when read edge led by first skew limit.
// - Empty flag releases on read edge when write edge led by first skew limit.
// - Write and read clocks may run throughout reset; edges are ignored then.
// - Second-enable/load pin level during reset picks its role until next reset.
// - After reset data outputs are low, driven when output enable low.
// - First word readable in read cycle after empty flag goes high.
// - First read latency at empty boundary is one read period plus skew.
// - Almost-empty updates on read edge when write led by second skew limit.
// - Almost-empty goes low when count falls below offset n.
// - Almost-full goes low when count reaches depth minus offset m plus one.
// - Almost-full updates on write edge when read led by second skew limit.
`timescale 1ns/1ps
module dual_clock_fifo_flags (
	// Clock and reset
	input  wire logic                                  clock,
	input  wire logic                                  sys_rst,
	// Device pins, all from outside the clock domain
	input  wire logic                                  wr_clk,
	input  wire logic                                  rd_clk,
	input  wire logic                                  fifo_reset_n,
	input  wire logic                                  wr_en_primary_n,
	input  wire logic                                  wr_en2_or_load,
	input  wire logic                                  rd_en_primary_n,
	input  wire logic                                  rd_en_secondary_n,
	input  wire logic                                  output_en_n,
	input  wire logic [fifo_flags_pkg::DATA_W-1:0]     data_in,
	// Data output, drive enable low while driving
	output logic      [fifo_flags_pkg::DATA_W-1:0]     data_out,
	output logic                                       data_oe_n,
	// Status flags, active low
	output logic                                       full_n,
	output logic                                       empty_n,
	output logic                                       almost_full_n,
	output logic                                       almost_empty_n
);
	import fifo_flags_pkg::*;

	logic [PIN_W-1:0]  pin_raw;
	logic [PIN_W-1:0]  s1_ff;
	logic [PIN_W-1:0]  s2_ff;
	logic [PIN_W-1:0]  s3_ff;
	logic [PIN_W-1:0]  flt_ff;
	logic              wr_edge;
	logic              rd_edge;
	logic              in_rst;
	logic              wr_ok;
	logic              ld_ok;
	logic              rd_ok;
	logic              load_mode_ff;
	logic              ld_sel_ff;
	logic [9:0]        ae_off_ff;
	logic [9:0]        af_off_ff;
	logic [PTR_W-1:0]  wptr_ff;
	logic [PTR_W-1:0]  rptr_ff;
	logic [PTR_W-1:0]  fptr_ff;
	logic [PTR_W-1:0]  nxt_wptr;
	logic [PTR_W-1:0]  nxt_rptr;
	logic [PROG_SKEW_CYC-1:0][PTR_W-1:0] wp_pipe_ff;
	logic [PROG_SKEW_CYC-1:0][PTR_W-1:0] rp_pipe_ff;
	logic [PTR_W-1:0]  rd_cnt_ae;
	logic [PTR_W-1:0]  wr_cnt_full;
	logic [11:0]       wr_sum_af;
	logic              ram_vld_ff;
	logic [DATA_W-1:0] ram_rdata;
	logic              issue;
	logic [1:0]        occupancy;
	logic [DATA_W-1:0] buf_ff [0:1];
	logic              head_ff;
	logic [1:0]        buf_cnt_ff;
	logic              full_n_ff;
	logic              empty_n_ff;
	logic              af_n_ff;
	logic              ae_n_ff;
	logic [DATA_W-1:0] data_out_ff;
	logic              data_oe_n_ff;

	assign pin_raw = {data_in, output_en_n, fifo_reset_n, rd_en_secondary_n, rd_en_primary_n,
		wr_en2_or_load, wr_en_primary_n, rd_clk, wr_clk};

	// A pin change counts only once the second and third stage agree
	genvar gi;
	generate
		for (gi = 0; gi < PIN_W; gi++) begin : g_sync
			always_ff @(posedge clock or posedge sys_rst) begin
				if (sys_rst) begin
					s1_ff[gi]  <= PIN_RST[gi];
					s2_ff[gi]  <= PIN_RST[gi];
					s3_ff[gi]  <= PIN_RST[gi];
					flt_ff[gi] <= PIN_RST[gi];
				end else begin
					s1_ff[gi] <= pin_raw[gi];
					s2_ff[gi] <= s1_ff[gi];
					s3_ff[gi] <= s2_ff[gi];
					if (s2_ff[gi] == s3_ff[gi]) begin
						flt_ff[gi] <= s3_ff[gi];
					end
				end
			end
		end
	endgenerate

	assign wr_edge = s2_ff[PIN_WCLK] & s3_ff[PIN_WCLK] & ~flt_ff[PIN_WCLK];
	assign rd_edge = s2_ff[PIN_RCLK] & s3_ff[PIN_RCLK] & ~flt_ff[PIN_RCLK];
	// Edges seen while reset is held are dropped, so free-running clocks are harmless
	assign in_rst  = ~flt_ff[PIN_RST_N];
	assign wr_ok   = wr_edge & ~in_rst & ~flt_ff[PIN_WR_EN_N] & ~load_mode_ff & flt_ff[PIN_WR_EN2]
		& full_n_ff;
	assign ld_ok   = wr_edge & ~in_rst & ~flt_ff[PIN_WR_EN_N] & load_mode_ff & ~flt_ff[PIN_WR_EN2];
	// The buffer must hold a word too; it always does by the time empty_n rises
	assign rd_ok   = rd_edge & ~in_rst & ~flt_ff[PIN_RD_EN_N] & ~flt_ff[PIN_RD_EN2_N] & empty_n_ff
		& (buf_cnt_ff != 2'h0);
	assign nxt_wptr = wptr_ff + PTR_W'(wr_ok);
	assign nxt_rptr = rptr_ff + PTR_W'(rd_ok);

	// Pin role is caught continuously while reset is held, then frozen
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			load_mode_ff <= 1'b0;
			ae_off_ff    <= OFFSET_RST;
			af_off_ff    <= OFFSET_RST;
			ld_sel_ff    <= 1'b0;
		end else if (in_rst) begin
			load_mode_ff <= ~flt_ff[PIN_WR_EN2];
			ae_off_ff    <= OFFSET_RST;
			af_off_ff    <= OFFSET_RST;
			ld_sel_ff    <= 1'b0;
		end else if (ld_ok) begin
			if (ld_sel_ff) begin
				af_off_ff <= {1'b0, flt_ff[PIN_DATA +: DATA_W]};
			end else begin
				ae_off_ff <= {1'b0, flt_ff[PIN_DATA +: DATA_W]};
			end
			ld_sel_ff <= ~ld_sel_ff;
		end
	end

	// Each side sees the other's pointer only after the skew window has passed
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			wptr_ff    <= '0;
			rptr_ff    <= '0;
			wp_pipe_ff <= '0;
			rp_pipe_ff <= '0;
		end else if (in_rst) begin
			wptr_ff    <= '0;
			rptr_ff    <= '0;
			wp_pipe_ff <= '0;
			rp_pipe_ff <= '0;
		end else begin
			wptr_ff    <= nxt_wptr;
			rptr_ff    <= nxt_rptr;
			wp_pipe_ff <= {wp_pipe_ff[PROG_SKEW_CYC-2:0], wptr_ff};
			rp_pipe_ff <= {rp_pipe_ff[PROG_SKEW_CYC-2:0], rptr_ff};
		end
	end

	fifo_ram u_ram (
		.clock    (clock),
		.we       (wr_ok),
		.waddr    (wptr_ff[ADDR_W-1:0]),
		.wdata    (flt_ff[PIN_DATA +: DATA_W]),
		.raddr    (fptr_ff[ADDR_W-1:0]),
		.rdata_ff (ram_rdata)
	);

	// Prefetch into a two-entry buffer; a full buffer stalls the fetch
	assign occupancy = buf_cnt_ff + {1'b0, ram_vld_ff};
	assign issue     = (fptr_ff != wptr_ff) & (occupancy < 2'h2);

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			fptr_ff    <= '0;
			ram_vld_ff <= 1'b0;
			head_ff    <= 1'b0;
			buf_cnt_ff <= 2'h0;
		end else if (in_rst) begin
			fptr_ff    <= '0;
			ram_vld_ff <= 1'b0;
			head_ff    <= 1'b0;
			buf_cnt_ff <= 2'h0;
		end else begin
			fptr_ff    <= fptr_ff + PTR_W'(issue);
			ram_vld_ff <= issue;
			head_ff    <= head_ff ^ rd_ok;
			buf_cnt_ff <= buf_cnt_ff + {1'b0, ram_vld_ff} - {1'b0, rd_ok};
		end
	end

	always_ff @(posedge clock) begin
		if (ram_vld_ff) begin
			buf_ff[head_ff ^ buf_cnt_ff[0]] <= ram_rdata;
		end
	end

	// Empty side: updated on read edges only
	assign rd_cnt_ae = wp_pipe_ff[PROG_SKEW_CYC-1] - nxt_rptr;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			empty_n_ff <= 1'b0;
			ae_n_ff    <= 1'b0;
		end else if (in_rst) begin
			empty_n_ff <= 1'b0;
			ae_n_ff    <= 1'b0;
		end else if (rd_edge) begin
			empty_n_ff <= wp_pipe_ff[FLAG_SKEW_CYC-1] != nxt_rptr;
			ae_n_ff    <= rd_cnt_ae >= {1'b0, ae_off_ff};
		end
	end

	// Full side: updated on write edges only
	assign wr_cnt_full = nxt_wptr - rp_pipe_ff[FLAG_SKEW_CYC-1];
	assign wr_sum_af   = {1'b0, nxt_wptr - rp_pipe_ff[PROG_SKEW_CYC-1]} + {2'h0, af_off_ff};

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			full_n_ff <= 1'b1;
			af_n_ff   <= 1'b1;
		end else if (in_rst) begin
			full_n_ff <= 1'b1;
			af_n_ff   <= 1'b1;
		end else if (wr_edge) begin
			full_n_ff <= {1'b0, wr_cnt_full} != DEPTH;
			af_n_ff   <= wr_sum_af <= DEPTH;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			data_out_ff  <= '0;
			data_oe_n_ff <= 1'b1;
		end else begin
			data_oe_n_ff <= flt_ff[PIN_OE_N];
			if (in_rst) begin
				data_out_ff <= '0;
			end else if (rd_ok) begin
				data_out_ff <= buf_ff[head_ff];
			end
		end
	end

	assign data_out       = data_out_ff;
	assign data_oe_n      = data_oe_n_ff;
	assign full_n         = full_n_ff;
	assign empty_n        = empty_n_ff;
	assign almost_full_n  = af_n_ff;
	assign almost_empty_n = ae_n_ff;

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	property p_full_on_wr_edge;
		!$stable(full_n_ff) |-> $past(wr_edge) || $past(in_rst);
	endproperty
	a_full_on_wr_edge: assert property (p_full_on_wr_edge) else $error("full_n moved off a write edge");
	property p_empty_on_rd_edge;
		!$stable(empty_n_ff) |-> $past(rd_edge) || $past(in_rst);
	endproperty
	a_empty_on_rd_edge: assert property (p_empty_on_rd_edge) else $error("empty_n moved off a read edge");
	property p_mode_frozen;
		!in_rst && !$past(in_rst) |-> $stable(load_mode_ff);
	endproperty
	a_mode_frozen: assert property (p_mode_frozen) else $error("pin role changed outside reset");
	property p_reset_outputs;
		in_rst |=> data_out_ff == '0 && !empty_n_ff && full_n_ff;
	endproperty
	a_reset_outputs: assert property (p_reset_outputs) else $error("bad output state in reset");
	property p_first_word_ready;
		$rose(empty_n_ff) |-> buf_cnt_ff != 2'h0;
	endproperty
	a_first_word_ready: assert property (p_first_word_ready) else $error("no word when empty_n rose");
	property p_ae_low;
		rd_edge && !in_rst && rd_cnt_ae < {1'b0, ae_off_ff} |=> !ae_n_ff;
	endproperty
	a_ae_low: assert property (p_ae_low) else $error("almost_empty_n not low");
	property p_af_low;
		wr_edge && !in_rst && wr_sum_af > DEPTH |=> !af_n_ff;
	endproperty
	a_af_low: assert property (p_af_low) else $error("almost_full_n not low");
	property p_no_write_full;
		{1'b0, wptr_ff - rptr_ff} <= DEPTH;
	endproperty
	a_no_write_full: assert property (p_no_write_full) else $error("stored count above depth");
	property p_offset_default;
		in_rst |=> ae_off_ff == OFFSET_RST && af_off_ff == OFFSET_RST;
	endproperty
	a_offset_default: assert property (p_offset_default) else $error("offsets not reset to default");

	c_read: cover property (rd_ok);
	c_full: cover property ($fell(full_n_ff));
	c_load: cover property (ld_ok);
endmodule

//--- sim/fifo_pin_agent.sv
`timescale 1ns/1ps
module fifo_pin_agent (
	// Clock
	input  wire logic                          clock,
	// Writer side
	output logic                               wr_clk,
	output logic                               fifo_reset_n,
	output logic                               wr_en_primary_n,
	output logic                               wr_en2_or_load,
	output logic [fifo_flags_pkg::DATA_W-1:0]  data_in,
	// Reader side
	output logic                               rd_clk,
	output logic                               rd_en_primary_n,
	output logic                               rd_en_secondary_n
);
	import fifo_flags_pkg::*;
	initial begin
		wr_clk = 1'b0;
		rd_clk = 1'b0;
		fifo_reset_n = 1'b0;
		wr_en_primary_n = 1'b1;
		wr_en2_or_load = 1'b1;
		rd_en_primary_n = 1'b1;
		rd_en_secondary_n = 1'b1;
		data_in = 9'h000;
	end
	// One pin clock cycle; four-clock phases so the sampler sees every edge
	task automatic pulse(input logic wr, input logic en, input logic pin2, input logic [DATA_W-1:0] d);
		@(negedge clock);
		if (wr) begin
			wr_en_primary_n = ~en;
			wr_en2_or_load = pin2;
			data_in = d;
		end else begin
			rd_en_primary_n = ~en;
			rd_en_secondary_n = ~en;
		end
		@(negedge clock);
		wr_clk = wr;
		rd_clk = ~wr;
		repeat (4) @(negedge clock);
		wr_clk = 1'b0;
		rd_clk = 1'b0;
		repeat (4) @(negedge clock);
		wr_en_primary_n = 1'b1;
		rd_en_primary_n = 1'b1;
		rd_en_secondary_n = 1'b1;
		if (fifo_reset_n)
			wr_en2_or_load = 1'b1;
		// Released bus shows the inverse, so a stale word never passes as fresh
		data_in = ~data_in;
	endtask
	task automatic reset_dev(input logic role);
		@(negedge clock);
		fifo_reset_n = 1'b0;
		wr_en2_or_load = role;
		pulse(1'b1, 1'b1, role, 9'h0f0);
		pulse(1'b0, 1'b1, role, 9'h000);
		fifo_reset_n = 1'b1;
		repeat (10) @(negedge clock);
		wr_en2_or_load = 1'b1;
	endtask
endmodule

//--- sim/testbench.sv
`timescale 1ns/1ps
module testbench;
	import fifo_flags_pkg::*;
	logic              clock, sys_rst, output_en_n;
	logic              wr_clk, rd_clk, fifo_reset_n, wr_en_primary_n, wr_en2_or_load;
	logic              rd_en_primary_n, rd_en_secondary_n, data_oe_n;
	logic              full_n, empty_n, almost_full_n, almost_empty_n;
	logic [DATA_W-1:0] data_in, data_out;
	int                errors, comparisons, cycles, k;
	dual_clock_fifo_flags DUT (.clock(clock), .sys_rst(sys_rst), .wr_clk(wr_clk), .rd_clk(rd_clk),
		.fifo_reset_n(fifo_reset_n), .wr_en_primary_n(wr_en_primary_n), .wr_en2_or_load(wr_en2_or_load),
		.rd_en_primary_n(rd_en_primary_n), .rd_en_secondary_n(rd_en_secondary_n),
		.output_en_n(output_en_n), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
		.full_n(full_n), .empty_n(empty_n), .almost_full_n(almost_full_n), .almost_empty_n(almost_empty_n));
	fifo_pin_agent agent (.clock(clock), .wr_clk(wr_clk), .fifo_reset_n(fifo_reset_n),
		.wr_en_primary_n(wr_en_primary_n), .wr_en2_or_load(wr_en2_or_load), .data_in(data_in),
		.rd_clk(rd_clk), .rd_en_primary_n(rd_en_primary_n), .rd_en_secondary_n(rd_en_secondary_n));
	initial clock = 1'b0;
	always #2 clock = ~clock;
	task automatic summarize();
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Whole run is about 20700 cycles
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			errors = errors + 1;
			summarize();
		end
	end
	task automatic check_flag(input string n, input logic e, input logic s);
		comparisons++;
		if (s !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %b seen %b", n, e, s);
		end
	endtask
	task automatic check_word(input string n, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] s);
		comparisons++;
		if (s !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic en, input logic [DATA_W-1:0] d);
		agent.pulse(1'b1, en, 1'b1, d);
	endtask
	task automatic rd(input logic en);
		agent.pulse(1'b0, en, 1'b1, 9'h000);
	endtask
	initial begin
		errors = 0;
		comparisons = 0;
		cycles = 0;
		sys_rst = 1'b1;
		output_en_n = 1'b0;
		repeat (20) @(negedge clock);
		sys_rst = 1'b0;
		agent.reset_dev(1'b1);
		check_word("data_out", 9'h000, data_out);
		check_flag("data_oe_n", 1'b0, data_oe_n);
		check_flag("empty_n", 1'b0, empty_n);
		check_flag("full_n", 1'b1, full_n);
		check_flag("almost_empty_n", 1'b0, almost_empty_n);
		check_flag("almost_full_n", 1'b1, almost_full_n);
		// Load mode: a load cycle must not store a word
		agent.reset_dev(1'b0);
		agent.pulse(1'b1, 1'b1, 1'b0, 9'h003);
		rd(1'b0);
		rd(1'b0);
		check_flag("empty_n", 1'b0, empty_n);
		output_en_n = 1'b1;
		repeat (6) @(negedge clock);
		check_flag("data_oe_n", 1'b1, data_oe_n);
		output_en_n = 1'b0;
		agent.reset_dev(1'b1);
		// Empty exit and first word
		wr(1'b1, 9'h1a5);
		for (k = 0; k < 4 && empty_n !== 1'b1; k++)
			rd(1'b0);
		check_flag("empty_n", 1'b1, empty_n);
		rd(1'b1);
		check_word("data_out", 9'h1a5, data_out);
		rd(1'b0);
		check_flag("empty_n", 1'b0, empty_n);
		// Fill to the top, then one refused write
		for (k = 0; k < 1024; k++) begin
			wr(1'b1, k[8:0] ^ 9'h0aa);
			if (k == 1016)
				check_flag("almost_full_n", 1'b1, almost_full_n);
			if (k == 1017)
				check_flag("almost_full_n", 1'b0, almost_full_n);
		end
		check_flag("full_n", 1'b0, full_n);
		wr(1'b1, 9'h077);
		rd(1'b0);
		check_flag("almost_empty_n", 1'b1, almost_empty_n);
		rd(1'b1);
		check_word("data_out", 9'h0aa, data_out);
		wr(1'b0, 9'h000);
		check_flag("full_n", 1'b1, full_n);
		check_flag("almost_full_n", 1'b0, almost_full_n);
		// Drain in order; the refused word never shows
		for (k = 1; k < 1024; k++) begin
			rd(1'b1);
			check_word("data_out", k[8:0] ^ 9'h0aa, data_out);
			if (k == 1016)
				check_flag("almost_empty_n", 1'b1, almost_empty_n);
			if (k == 1017)
				check_flag("almost_empty_n", 1'b0, almost_empty_n);
		end
		check_flag("empty_n", 1'b0, empty_n);
		rd(1'b1);
		check_word("data_out", 9'h155, data_out);
		summarize();
	end
endmodule
